// >>> rtl/irmap_top.sv
`timescale 1ns/1ps
//
// Contract
// - Pixels indexed row 0..3, column 0..15
// - 146-word 16-bit result memory, read only
// - One signed pixel word per pixel
// - One unsigned ambient sensor word
// - Pixel address row plus four times column
// - Operating configuration at 0x92, read/write
// - Low four config bits pick refresh rate
module irmap_top (
   mclk,
   rst_n,
   meas_valid,
   meas_row,
   meas_col,
   meas_pixel,
   amb_valid,
   amb_data,
   comp_valid,
   comp_data,
   rd_en,
   rd_addr,
   rd_data,
   wr_en,
   wr_addr,
   wr_data,
   operating_config,
   rate_shift
);
   input wire logic mclk;
   input wire logic rst_n;
   input wire logic meas_valid;
   input wire logic [1:0] meas_row;
   input wire logic [3:0] meas_col;
   input wire logic signed [15:0] meas_pixel;
   input wire logic amb_valid;
   input wire logic [15:0] amb_data;
   input wire logic comp_valid;
   input wire logic signed [15:0] comp_data;
   input wire logic rd_en;
   input wire logic [7:0] rd_addr;
   output logic [15:0] rd_data;
   input wire logic wr_en;
   input wire logic [7:0] wr_addr;
   input wire logic [15:0] wr_data;
   output logic [15:0] operating_config;
   output logic [3:0] rate_shift;

   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic [irmap_pkg::PIX_N-1:0][15:0] pix;
      logic [15:0] ambient;
      logic [15:0] comp;
      logic [15:0] cfg;
      logic [15:0] rdata;
   } irmap_state_t;

   irmap_state_t st_r;
   irmap_state_t st_nxt;
   logic [5:0] pix_idx;

   // Row in low bits, column above: address = r + 4*c
   assign pix_idx = {meas_col, meas_row};

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   // The bus port has no write path into result words; only the sensor side fills them
   always_comb begin
      st_nxt = st_r;
      if (meas_valid) begin
         st_nxt.pix[pix_idx] = meas_pixel;
      end
      if (amb_valid) begin
         st_nxt.ambient = amb_data;
      end
      if (comp_valid) begin
         st_nxt.comp = comp_data;
      end
      // Only 0x92 accepts writes; all else, the result memory included, is ignored
      if (wr_en && wr_addr == irmap_pkg::OPERATING_CONFIG_ADDR) begin
         st_nxt.cfg = wr_data;
      end
      if (rd_en) begin
         if (rd_addr <= irmap_pkg::PIX_LAST_ADDR) begin
            st_nxt.rdata = st_r.pix[rd_addr[5:0]];
         end else if (rd_addr == irmap_pkg::AMBIENT_ADDR) begin
            st_nxt.rdata = st_r.ambient;
         end else if (rd_addr == irmap_pkg::COMP_PIXEL_ADDR) begin
            st_nxt.rdata = st_r.comp;
         end else if (rd_addr == irmap_pkg::OPERATING_CONFIG_ADDR) begin
            st_nxt.rdata = st_r.cfg;
         end else begin
            // 0x42..0x91 is unpopulated result space; rest is unmapped
            st_nxt.rdata = irmap_pkg::UNUSED_READ;
         end
      end
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   // Results clear to zero so reads before the first frame are defined
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         st_r <= '0;
         st_r.cfg <= irmap_pkg::CONFIG_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign rd_data = st_r.rdata;
   assign operating_config = st_r.cfg;

   irmap_rate_dec u_rate (
      .rate_code(st_r.cfg[irmap_pkg::RATE_LSB +: irmap_pkg::RATE_W]),
      .rate_shift(rate_shift)
   );

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   pix_read_back_a: assert property (@(posedge mclk) disable iff (!rst_n)
      meas_valid ##1 (rd_en && !meas_valid && rd_addr == {2'b00, $past(meas_col), $past(meas_row)})
      |=> rd_data == $past(meas_pixel, 2))
      else $error("pixel word not at row plus four times column");
   amb_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (amb_valid ##1 (rd_en && !amb_valid && rd_addr == 8'h40)) |=> rd_data == $past(amb_data, 2))
      else $error("ambient word not at 0x40");
   comp_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (comp_valid ##1 (rd_en && !comp_valid && rd_addr == 8'h41)) |=> rd_data == $past(comp_data, 2))
      else $error("compensation word not at 0x41");
   cfg_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_en && wr_addr == 8'h92) |=> operating_config == $past(wr_data))
      else $error("config write not taken");
   cfg_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !(wr_en && wr_addr == 8'h92) |=> $stable(operating_config))
      else $error("config changed without a write to 0x92");
   unused_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && rd_addr > 8'h41 && rd_addr != 8'h92) |=> rd_data == 16'h0000)
      else $error("unused address returned data");
   // Checked on the stored words themselves, so a stray write shows up at once
   ram_ro_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (wr_en && !meas_valid && !amb_valid && !comp_valid)
      |=> $stable(st_r.pix) && $stable(st_r.ambient) && $stable(st_r.comp))
      else $error("result memory altered by bus write");
   rate_dec_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (operating_config[3:0] == 4'hE) |-> rate_shift == 4'h9)
      else $error("1 Hz code decoded wrongly");

   // ----------------------------------------
   // Assertions: reset and read port
   // ----------------------------------------
   // Left outside disable iff on purpose: it is the reset itself that is checked
   reset_dflt_a: assert property (@(posedge mclk)
      !rst_n |=> operating_config == irmap_pkg::CONFIG_RESET && rd_data == 16'h0000)
      else $error("reset did not restore the defaults");
   // A host may poll slowly, so read data must not drift between reads
   rd_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !rd_en |=> $stable(rd_data))
      else $error("read data moved without a read");
   // A read in the same cycle as a write to 0x92 returns the old value
   cfg_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && rd_addr == irmap_pkg::OPERATING_CONFIG_ADDR)
      |=> rd_data == $past(operating_config))
      else $error("config read back wrong");
   // Result words read back from their fixed places in the map
   pix_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && rd_addr <= irmap_pkg::PIX_LAST_ADDR)
      |=> rd_data == $past(st_r.pix[rd_addr[5:0]]))
      else $error("pixel word read from the wrong place");
   amb_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && rd_addr == irmap_pkg::AMBIENT_ADDR) |=> rd_data == $past(st_r.ambient))
      else $error("ambient word read from the wrong place");
   comp_map_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (rd_en && rd_addr == irmap_pkg::COMP_PIXEL_ADDR) |=> rd_data == $past(st_r.comp))
      else $error("compensation word read from the wrong place");

   // ----------------------------------------
   // Assertions: sensor side
   // ----------------------------------------
   // A strobed word must be in place one cycle later or a prompt read sees stale data
   pix_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
      meas_valid |=> st_r.pix[$past(pix_idx)] == $past(meas_pixel))
      else $error("pixel word not stored");
   amb_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
      amb_valid |=> st_r.ambient == $past(amb_data))
      else $error("ambient word not stored");
   comp_store_a: assert property (@(posedge mclk) disable iff (!rst_n)
      comp_valid |=> st_r.comp == $past(comp_data))
      else $error("compensation word not stored");
   // Results are only ever rewritten by their own strobe
   amb_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !amb_valid |=> $stable(st_r.ambient))
      else $error("ambient word changed without its strobe");
   comp_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
      !comp_valid |=> $stable(st_r.comp))
      else $error("compensation word changed without its strobe");
   // Address worked out as row plus four times column, apart from pix_idx
   for (genvar gi = 0; gi < irmap_pkg::PIX_N; gi++) begin : g_pix_hold
      pix_hold_a: assert property (@(posedge mclk) disable iff (!rst_n)
         !(meas_valid && 6'(meas_row) + 6'h4 * 6'(meas_col) == 6'(gi))
         |=> $stable(st_r.pix[gi]))
         else $error("pixel word changed without its own strobe");
   end

   // ----------------------------------------
   // Assertions: refresh-rate decode
   // ----------------------------------------
   // All codes at or below the fastest one saturate at 512 Hz
   rate_sat_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (operating_config[3:0] <= irmap_pkg::RATE_CODE_512) |-> rate_shift == 4'h0)
      else $error("fast codes not saturated at 512 Hz");
   // Every code above that halves the rate once more
   rate_step_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (operating_config[3:0] > irmap_pkg::RATE_CODE_512)
      |-> rate_shift + irmap_pkg::RATE_CODE_512 == operating_config[3:0])
      else $error("slow codes not halving the rate");
   // Top code must give ten halvings, that is 0.5 Hz
   rate_slow_a: assert property (@(posedge mclk) disable iff (!rst_n)
      (operating_config[3:0] == 4'hF) |-> rate_shift == 4'hA)
      else $error("0.5 Hz code decoded wrongly");
endmodule // irmap_top

// >>> rtl/irmap_pkg.sv
package irmap_pkg;
   // ----------------------------------------
   // Array geometry
   // ----------------------------------------
   localparam int ROWS = 4;
   localparam int COLS = 16;
   localparam int PIX_N = 64;
   localparam int WORD_W = 16;
   localparam int ADDR_W = 8;
   localparam int RAM_WORDS = 146;
   // ----------------------------------------
   // Address map
   // ----------------------------------------
   localparam logic [7:0] PIX_LAST_ADDR = 8'h3F;
   localparam logic [7:0] AMBIENT_ADDR = 8'h40;
   localparam logic [7:0] COMP_PIXEL_ADDR = 8'h41;
   localparam logic [7:0] RAM_LAST_ADDR = 8'h91;
   localparam logic [7:0] OPERATING_CONFIG_ADDR = 8'h92;
   // ----------------------------------------
   // Configuration fields and reset value
   // ----------------------------------------
   localparam int RATE_LSB = 0;
   localparam int RATE_W = 4;
   localparam logic [15:0] CONFIG_RESET = 16'h040E;
   localparam logic [3:0] RATE_CODE_512 = 4'h5;
   localparam logic [15:0] UNUSED_READ = 16'h0000;
endpackage

// >>> rtl/irmap_rate_dec.sv
`timescale 1ns/1ps
// Turns a refresh-rate code into a halving exponent: 0 means 512 Hz, 10 means 0.5 Hz
module irmap_rate_dec (
   input wire logic [3:0] rate_code,
   output logic [3:0] rate_shift
);
   // ----------------------------------------
   // Decode
   // ----------------------------------------
   // Codes 0..5 all saturate at the fastest rate
   always_comb begin
      if (rate_code <= irmap_pkg::RATE_CODE_512) begin
         rate_shift = 4'h0;
      end else begin
         rate_shift = rate_code - irmap_pkg::RATE_CODE_512;
      end
   end
endmodule // irmap_rate_dec

// >>> tb/irmap_host.sv
`timescale 1ns/1ps
// Bus controller model: one-cycle strobes, address turned over once released
module irmap_host (
   input wire logic mclk,
   input wire logic [15:0] rd_data,
   output logic rd_en,
   output logic [7:0] rd_addr,
   output logic wr_en,
   output logic [7:0] wr_addr,
   output logic [15:0] wr_data
);
   initial {rd_en, rd_addr, wr_en, wr_addr, wr_data} = '0;
   task automatic rd(input logic [7:0] a, output logic [15:0] d);
      @(posedge mclk);
      rd_en <= 1'b1;
      rd_addr <= a;
      @(posedge mclk);
      rd_en <= 1'b0;
      rd_addr <= ~a;
      #1;
      d = rd_data;
   endtask
   // Writes are legal at any address; only the device decides what lands
   task automatic wr(input logic [7:0] a, input logic [15:0] v);
      @(posedge mclk);
      wr_en <= 1'b1;
      {wr_addr, wr_data} <= {a, v};
      @(posedge mclk);
      wr_en <= 1'b0;
      {wr_addr, wr_data} <= ~{a, v};
      #1;
   endtask
endmodule // irmap_host

// >>> tb/irmap_top_test.sv
`timescale 1ns/1ps
module irmap_top_test;
   logic mclk = 1'b0, rst_n = 1'b0, meas_valid = 1'b0, amb_valid = 1'b0, comp_valid = 1'b0;
   logic [1:0] meas_row = '0;
   logic [3:0] meas_col = '0;
   logic [15:0] meas_pixel = '0, amb_data = '0, comp_data = '0, d;
   logic rd_en, wr_en;
   logic [7:0] rd_addr, wr_addr;
   logic [15:0] rd_data, wr_data, operating_config;
   logic [3:0] rate_shift;
   int miscompares = 0, tests_run = 0;
   // Free-running 20 MHz clock
   always #25 mclk = ~mclk;
   irmap_top uut (.mclk(mclk), .rst_n(rst_n), .meas_valid(meas_valid), .meas_row(meas_row),
      .meas_col(meas_col), .meas_pixel(meas_pixel), .amb_valid(amb_valid), .amb_data(amb_data),
      .comp_valid(comp_valid), .comp_data(comp_data), .rd_en(rd_en), .rd_addr(rd_addr),
      .rd_data(rd_data), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data),
      .operating_config(operating_config), .rate_shift(rate_shift));
   irmap_host h (.mclk(mclk), .rd_data(rd_data), .rd_en(rd_en), .rd_addr(rd_addr),
      .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Sensor side write: k 0 pixel, 1 ambient, 2 compensation
   task automatic sw(input int k, input int r, input int c, input logic [15:0] v);
      @(posedge mclk);
      {meas_valid, amb_valid, comp_valid} <= {k == 0, k == 1, k == 2};
      {meas_row, meas_col} <= {2'(r), 4'(c)};
      {meas_pixel, amb_data, comp_data} <= {v, v, v};
      @(posedge mclk);
      {meas_valid, amb_valid, comp_valid} <= 3'b000;
      meas_pixel <= ~v;
   endtask
   task automatic t_pix();
      for (int c = 0; c < 16; c++) for (int r = 0; r < 4; r++) sw(0, r, c, 16'(-(r + 4 * c) - 1));
      for (int c = 0; c < 16; c++) for (int r = 0; r < 4; r++) begin
         h.rd(8'(r + 4 * c), d);
         chk(d, 16'(-(r + 4 * c) - 1));
      end
   endtask
   task automatic t_amb();
      sw(1, 0, 0, 16'hFFFE);
      sw(2, 0, 0, 16'h8001);
      h.rd(8'h40, d);
      chk(d, 16'hFFFE);
      h.rd(8'h41, d);
      chk(d, 16'h8001);
   endtask
   // Writes outside the config word must leave results and config alone
   task automatic t_ro();
      h.wr(8'h05, 16'h1234);
      h.wr(8'h40, 16'h1234);
      h.rd(8'h05, d);
      chk(d, 16'hFFFA);
      h.rd(8'h40, d);
      chk(d, 16'hFFFE);
      chk(operating_config, 16'h040E);
      for (int i = 0; i < 4; i++) begin
         h.rd(i == 0 ? 8'h42 : i == 1 ? 8'h91 : i == 2 ? 8'h93 : 8'hFF, d);
         chk(d, 16'h0000);
      end
   endtask
   task automatic t_cfg();
      for (int k = 0; k < 16; k++) begin
         h.wr(8'h92, 16'hA500 | 16'(k));
         chk({12'h000, rate_shift}, 16'(k < 6 ? 0 : k - 5));
         h.rd(8'h92, d);
         chk(d, 16'hA500 | 16'(k));
      end
   endtask
   // A read one cycle after a sensor strobe must already see the new word
   task automatic t_fresh();
      for (int k = 0; k < 3; k++) begin
         fork
            sw(k, 2, 8, 16'h7A00 | 16'(k));
            begin
               @(posedge mclk);
               h.rd(k == 0 ? 8'h22 : k == 1 ? 8'h40 : 8'h41, d);
            end
         join
         chk(d, 16'h7A00 | 16'(k));
      end
   endtask
   // Mid-run reset must bring back the 1 Hz default and clear stale results
   task automatic t_reset();
      h.wr(8'h92, 16'h0003);
      @(posedge mclk);
      rst_n <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chk(operating_config, 16'h040E);
      chk({12'h000, rate_shift}, 16'h0009);
      h.rd(8'h40, d);
      chk(d, 16'h0000);
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", tests_run, miscompares);
      if (miscompares == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // Watchdog cuts a hang short
   initial begin
      #100000;
      miscompares++;
      end_sim();
   end
   initial begin
      repeat (3) @(posedge mclk);
      rst_n <= 1'b1;
      chk(operating_config, 16'h040E);
      chk({12'h000, rate_shift}, 16'h0009);
      t_pix();
      t_amb();
      t_ro();
      t_fresh();
      t_cfg();
      t_reset();
      end_sim();
   end
endmodule // irmap_top_test
